// [hdl/ied_pkg.sv]
// Constants and types of the instruction exception detector.
// Assumes the decode stage has already sorted each instruction into one class code.
package ied_pkg;

  // Class code that decode attaches to the instruction it hands over.
  typedef enum logic [3:0] {
    IED_CLS_OTHER       = 4'h0, // Ordinary instruction, no special handling.
    IED_CLS_UNDEFINED   = 4'h1, // Opcode that decodes to nothing.
    IED_CLS_SW_TRAP     = 4'h2, // The software_trap instruction.
    IED_CLS_DLY_BRANCH  = 4'h3, // Any delayed branch, returns included.
    IED_CLS_PC_NO_SLOT  = 4'h4, // PC writers without a slot: if_true_jump and the like.
    IED_CLS_WIDE        = 4'h5, // Any 32-bit wide instruction.
    IED_CLS_BANK_REST   = 4'h6, // The bank_restore instruction.
    IED_CLS_SIGNED_DIV  = 4'h7, // The signed_divide instruction.
    IED_CLS_UNSIGN_DIV  = 4'h8, // The unsigned_divide instruction.
    IED_CLS_FP_ARITH    = 4'h9  // Float arithmetic, compare, convert, truncate, root.
  } ied_class_t;

  // Exception type reported to the handling sequencer.
  typedef enum logic [2:0] {
    IED_EXC_NONE         = 3'h0, // No exception.
    IED_EXC_TRAP         = 3'h1, // Software trap.
    IED_EXC_SLOT_ILLEGAL = 3'h2, // Illegal content of a delay slot.
    IED_EXC_GEN_ILLEGAL  = 3'h3, // Undefined opcode outside a slot.
    IED_EXC_INT_DIV      = 3'h4, // Integer division fault.
    IED_EXC_FLOAT        = 3'h5  // Floating-point fault.
  } ied_exc_t;

  // Report stage state, one-hot.
  typedef enum logic [1:0] {
    IED_ST_IDLE   = 2'b01, // Nothing reported this cycle.
    IED_ST_REPORT = 2'b10  // An exception is on the outputs this cycle.
  } ied_state_t;

  // Operand width of the integer divider.
  localparam int unsigned IED_DATA_W = 32;

  // Operand patterns that make a division fail.
  localparam logic [31:0] IED_ZERO      = 32'h0000_0000;
  localparam logic [31:0] IED_MOST_NEG  = 32'h8000_0000;
  localparam logic [31:0] IED_MINUS_ONE = 32'hffff_ffff;

  // Positions of the floating-point fault flags, in the usual IEEE order.
  localparam int unsigned IED_FPF_INVALID  = 4;
  localparam int unsigned IED_FPF_DIVZERO  = 3;
  localparam int unsigned IED_FPF_OVERFLOW = 2;
  localparam int unsigned IED_FPF_UNDERFLW = 1;
  localparam int unsigned IED_FPF_INEXACT  = 0;
  localparam int unsigned IED_FPF_W        = 5;

endpackage

// [hdl/ied_detector.sv]
// Instruction exception detector: classifies one executing instruction per cycle
// and reports at most one exception for it, one cycle later, from flip-flops.
// Assumes decode supplies a class code and the slot flag, and execute supplies
// divide operands and floating-point fault flags in the same cycle as the strobe.
`timescale 1ns/1ps

module ied_detector (
  input  wire logic                          i_core_clk,       // CPU clock, 100 MHz.
  input  wire logic                          i_rst,            // Synchronous reset, high.
  input  wire logic                          i_instr_valid,    // Instruction executes now.
  input  wire ied_pkg::ied_class_t           i_instr_class,    // Decoded class of it.
  input  wire logic                          i_in_delay_slot,  // It sits in a delay slot.
  input  wire logic [ied_pkg::IED_DATA_W-1:0] i_dividend,      // Divide dividend.
  input  wire logic [ied_pkg::IED_DATA_W-1:0] i_divisor,       // Divide divisor.
  input  wire logic [ied_pkg::IED_FPF_W-1:0] i_fp_flags,       // Float fault flags.
  output logic                               o_exc_valid,      // Exception raised, pulse.
  output ied_pkg::ied_exc_t                  o_exc_type,       // Which exception.
  output logic                               o_suppress_result // Drop the write-back.
);

  // Current report state and its next value.
  ied_pkg::ied_state_t state;
  ied_pkg::ied_state_t next_state;

  // Next values of the registered outputs.
  ied_pkg::ied_exc_t   next_exc_type;
  logic                next_exc_valid;
  logic                next_suppress;

  // Individual detections; kept separate so the priority below is easy to read.
  logic slot_bad;   // Instruction forbidden in a delay slot.
  logic undef_op;   // Undefined opcode.
  logic div_fault;  // Integer divide fault.
  logic fp_fault;   // Floating-point fault.
  logic is_div;     // Either divide.

  // Classification of the current instruction.
  always_comb begin
    is_div   = (i_instr_class == ied_pkg::IED_CLS_SIGNED_DIV) ||
               (i_instr_class == ied_pkg::IED_CLS_UNSIGN_DIV);
    undef_op = (i_instr_class == ied_pkg::IED_CLS_UNDEFINED);
    // Every class that may not follow a delayed branch.
    slot_bad = 1'b0;
    unique case (i_instr_class)
      ied_pkg::IED_CLS_UNDEFINED: begin
        slot_bad = 1'b1;
      end
      ied_pkg::IED_CLS_DLY_BRANCH,
      ied_pkg::IED_CLS_PC_NO_SLOT,
      ied_pkg::IED_CLS_SW_TRAP: begin
        slot_bad = 1'b1;
      end
      ied_pkg::IED_CLS_WIDE: begin
        slot_bad = 1'b1;
      end
      ied_pkg::IED_CLS_BANK_REST,
      ied_pkg::IED_CLS_SIGNED_DIV,
      ied_pkg::IED_CLS_UNSIGN_DIV: begin
        slot_bad = 1'b1;
      end
      default: begin
        // Ordinary and float classes are legal in a slot.
        slot_bad = 1'b0;
      end
    endcase
    // Zero divisor faults both divides; the overflow case only the signed one.
    div_fault = is_div && (i_divisor == ied_pkg::IED_ZERO);
    if ((i_instr_class == ied_pkg::IED_CLS_SIGNED_DIV) &&
        (i_dividend == ied_pkg::IED_MOST_NEG) &&
        (i_divisor == ied_pkg::IED_MINUS_ONE)) begin
      div_fault = 1'b1;
    end
    // Any of the five flags counts; the unit does not mask them here.
    fp_fault = (i_instr_class == ied_pkg::IED_CLS_FP_ARITH) && (|i_fp_flags);
  end

  // Priority select. A slot violation is checked first, because an instruction
  // that must not sit in a slot never gets to execute, so its own trap, undefined
  // opcode or divide fault must not be seen. This also keeps the report to one type.
  always_comb begin
    next_exc_type = ied_pkg::IED_EXC_NONE;
    if (i_instr_valid) begin
      if (i_in_delay_slot && slot_bad) begin
        next_exc_type = ied_pkg::IED_EXC_SLOT_ILLEGAL;
      end else if (undef_op) begin
        next_exc_type = ied_pkg::IED_EXC_GEN_ILLEGAL;
      end else if (i_instr_class == ied_pkg::IED_CLS_SW_TRAP) begin
        next_exc_type = ied_pkg::IED_EXC_TRAP;
      end else if (div_fault) begin
        next_exc_type = ied_pkg::IED_EXC_INT_DIV;
      end else if (fp_fault) begin
        next_exc_type = ied_pkg::IED_EXC_FLOAT;
      end else begin
        next_exc_type = ied_pkg::IED_EXC_NONE;
      end
    end
    next_exc_valid = (next_exc_type != ied_pkg::IED_EXC_NONE);
    // Suppression travels with the report so write-back and handling agree.
    next_suppress  = next_exc_valid;
    next_state     = next_exc_valid ? ied_pkg::IED_ST_REPORT : ied_pkg::IED_ST_IDLE;
  end

  // Output registers; reset leaves no exception pending.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state             <= ied_pkg::IED_ST_IDLE;
      o_exc_valid       <= 1'b0;
      o_exc_type        <= ied_pkg::IED_EXC_NONE;
      o_suppress_result <= 1'b0;
    end else begin
      state             <= next_state;
      o_exc_valid       <= next_exc_valid;
      o_exc_type        <= next_exc_type;
      o_suppress_result <= next_suppress;
    end
  end

  // Checks, all in the one clock domain.
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  // Shorthand for the stimulus of the cycle under test.
  logic fresh; // Valid instruction outside a slot.
  logic slotv; // Valid instruction inside a slot.
  always_comb begin
    fresh = i_instr_valid && !i_in_delay_slot;
    slotv = i_instr_valid && i_in_delay_slot;
  end

  AST_TRAP: assert property (
    fresh && (i_instr_class == ied_pkg::IED_CLS_SW_TRAP)
    |=> o_exc_valid && (o_exc_type == ied_pkg::IED_EXC_TRAP))
    else $error("software trap not reported");

  AST_SLOT_UNDEF: assert property (
    slotv && (i_instr_class == ied_pkg::IED_CLS_UNDEFINED)
    |=> o_exc_type == ied_pkg::IED_EXC_SLOT_ILLEGAL)
    else $error("undefined slot opcode not slot illegal");

  AST_SLOT_PC: assert property (
    slotv && ((i_instr_class == ied_pkg::IED_CLS_DLY_BRANCH) ||
              (i_instr_class == ied_pkg::IED_CLS_PC_NO_SLOT) ||
              (i_instr_class == ied_pkg::IED_CLS_SW_TRAP))
    |=> o_exc_type == ied_pkg::IED_EXC_SLOT_ILLEGAL)
    else $error("PC writer in slot not slot illegal");

  AST_SLOT_WIDE: assert property (
    slotv && (i_instr_class == ied_pkg::IED_CLS_WIDE)
    |=> o_exc_type == ied_pkg::IED_EXC_SLOT_ILLEGAL)
    else $error("wide instruction in slot not slot illegal");

  AST_SLOT_BANKDIV: assert property (
    slotv && ((i_instr_class == ied_pkg::IED_CLS_BANK_REST) ||
              (i_instr_class == ied_pkg::IED_CLS_SIGNED_DIV) ||
              (i_instr_class == ied_pkg::IED_CLS_UNSIGN_DIV))
    |=> o_exc_type == ied_pkg::IED_EXC_SLOT_ILLEGAL)
    else $error("restore or divide in slot not slot illegal");

  AST_GEN_ILLEGAL: assert property (
    fresh && (i_instr_class == ied_pkg::IED_CLS_UNDEFINED)
    |=> o_exc_valid && (o_exc_type == ied_pkg::IED_EXC_GEN_ILLEGAL))
    else $error("undefined opcode not general illegal");

  AST_DIV_ZERO: assert property (
    fresh && ((i_instr_class == ied_pkg::IED_CLS_SIGNED_DIV) ||
              (i_instr_class == ied_pkg::IED_CLS_UNSIGN_DIV)) &&
    (i_divisor == ied_pkg::IED_ZERO)
    |=> o_exc_type == ied_pkg::IED_EXC_INT_DIV)
    else $error("divide by zero not reported");

  AST_DIV_OVF: assert property (
    fresh && (i_instr_class == ied_pkg::IED_CLS_SIGNED_DIV) &&
    (i_dividend == ied_pkg::IED_MOST_NEG) && (i_divisor == ied_pkg::IED_MINUS_ONE)
    |=> o_exc_type == ied_pkg::IED_EXC_INT_DIV)
    else $error("signed overflow divide not reported");

  AST_UDIV_NO_OVF: assert property (
    fresh && (i_instr_class == ied_pkg::IED_CLS_UNSIGN_DIV) &&
    (i_divisor != ied_pkg::IED_ZERO)
    |=> !o_exc_valid)
    else $error("unsigned divide faulted on nonzero divisor");

  // A float instruction with any flag set must fault, and one with none must not.
  AST_FLOAT: assert property (
    fresh && (i_instr_class == ied_pkg::IED_CLS_FP_ARITH) && (i_fp_flags != 5'h00)
    |=> o_exc_valid && (o_exc_type == ied_pkg::IED_EXC_FLOAT))
    else $error("float fault flags not reported");

  AST_FLOAT_CLEAN: assert property (
    fresh && (i_instr_class == ied_pkg::IED_CLS_FP_ARITH) && (i_fp_flags == 5'h00)
    |=> !o_exc_valid)
    else $error("float instruction faulted without a flag");

  AST_SUPPRESS: assert property (
    o_suppress_result == o_exc_valid &&
    o_exc_valid == (o_exc_type != ied_pkg::IED_EXC_NONE))
    else $error("suppress and report disagree");

  // No strobe means nothing at all on the report outputs one cycle later.
  AST_QUIET: assert property (
    !i_instr_valid |=> !o_exc_valid && !o_suppress_result &&
    (o_exc_type == ied_pkg::IED_EXC_NONE))
    else $error("report without an instruction");

  // The state register mirrors the report, so the two must never drift apart.
  AST_STATE: assert property (
    (state == ied_pkg::IED_ST_REPORT) == o_exc_valid)
    else $error("report state and valid flag disagree");

  COV_TRAP: cover property (
    fresh && (i_instr_class == ied_pkg::IED_CLS_SW_TRAP) ##1 o_exc_valid);
  COV_SLOT: cover property (o_exc_type == ied_pkg::IED_EXC_SLOT_ILLEGAL);
  COV_DIV_OVF: cover property (
    fresh && (i_dividend == ied_pkg::IED_MOST_NEG) &&
    (i_divisor == ied_pkg::IED_MINUS_ONE) ##1 o_exc_valid);
  COV_BACK2BACK: cover property (o_exc_valid ##1 o_exc_valid);

endmodule

// [tb/ied_pipe_model.sv]
// Model of the decode and execute stages that feed the exception detector.
// Assumes the bench calls its tasks; outputs change 1 ns after a rising edge.
`timescale 1ns/1ps

module ied_pipe_model (
  input  wire logic                      i_core_clk, // CPU clock.
  output logic                           o_valid,    // Instruction executes.
  output ied_pkg::ied_class_t            o_class,    // Its decoded class.
  output logic                           o_slot,     // It sits in a delay slot.
  output logic [ied_pkg::IED_DATA_W-1:0] o_dividend, // Divide dividend.
  output logic [ied_pkg::IED_DATA_W-1:0] o_divisor,  // Divide divisor.
  output logic [ied_pkg::IED_FPF_W-1:0]  o_fp_flags  // Float fault flags.
);
  // Between instructions the qualifiers turn to junk, so a detector that
  // ignores the strobe is caught rather than shielded by quiet zeros.
  task automatic go_idle();
    @(posedge i_core_clk);
    #1;
    o_valid    = 1'b0;
    o_class    = ied_pkg::IED_CLS_UNDEFINED;
    o_slot     = 1'b1;
    o_dividend = ~o_dividend;
    o_divisor  = ~o_divisor;
    o_fp_flags = ~o_fp_flags;
  endtask

  // Hands one instruction to the detector; it stays until the next task call.
  task automatic present(input ied_pkg::ied_class_t c, input logic s,
                         input logic [31:0] a, input logic [31:0] b, input logic [4:0] f);
    @(posedge i_core_clk);
    #1;
    o_valid    = 1'b1;
    o_class    = c;
    o_slot     = s;
    o_dividend = a;
    o_divisor  = b;
    o_fp_flags = f;
  endtask

  // Zero operands first, so the first idle pattern is defined.
  initial begin
    o_valid    = 1'b0;
    o_class    = ied_pkg::IED_CLS_OTHER;
    o_slot     = 1'b0;
    o_dividend = 32'h0000_0000;
    o_divisor  = 32'h0000_0000;
    o_fp_flags = 5'h00;
  end
endmodule

// [tb/instruction_exception_detector_test.sv]
// Self-checking bench of the instruction exception detector.
// Assumes the pipeline model drives every detector input except clock and reset.
`timescale 1ns/1ps

module instruction_exception_detector_test;
  logic                i_core_clk = 1'b0; // CPU clock, 10 ns period.
  logic                i_rst      = 1'b1; // Synchronous reset, high.
  logic                vld, slot;         // Strobe and slot flag from the model.
  ied_pkg::ied_class_t cls;               // Class from the model.
  logic [31:0]         dvd, dvs;          // Divide operands from the model.
  logic [4:0]          fpf;               // Float flags from the model.
  logic                exc_vld, sup;      // Detector report and suppress.
  ied_pkg::ied_exc_t   exc_type;          // Detector exception type.
  int                  error_cnt, total_checks, cyc;

  always #5 i_core_clk = ~i_core_clk;

  ied_pipe_model model (.i_core_clk(i_core_clk), .o_valid(vld), .o_class(cls), .o_slot(slot),
                        .o_dividend(dvd), .o_divisor(dvs), .o_fp_flags(fpf));
  ied_detector uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_instr_valid(vld),
                    .i_instr_class(cls), .i_in_delay_slot(slot), .i_dividend(dvd),
                    .i_divisor(dvs), .i_fp_flags(fpf), .o_exc_valid(exc_vld),
                    .o_exc_type(exc_type), .o_suppress_result(sup));

  // Expected report worked out from the class table; slot faults win over all else.
  function automatic ied_pkg::ied_exc_t want(ied_pkg::ied_class_t c, logic s,
                                             logic [31:0] a, logic [31:0] b, logic [4:0] f);
    if (s && c != ied_pkg::IED_CLS_OTHER && c != ied_pkg::IED_CLS_FP_ARITH)
      return ied_pkg::IED_EXC_SLOT_ILLEGAL;
    if (c == ied_pkg::IED_CLS_UNDEFINED) return ied_pkg::IED_EXC_GEN_ILLEGAL;
    if (c == ied_pkg::IED_CLS_SW_TRAP) return ied_pkg::IED_EXC_TRAP;
    if ((c == ied_pkg::IED_CLS_SIGNED_DIV || c == ied_pkg::IED_CLS_UNSIGN_DIV) && b == 0)
      return ied_pkg::IED_EXC_INT_DIV;
    if (c == ied_pkg::IED_CLS_SIGNED_DIV && a == 32'h8000_0000 && b == 32'hffff_ffff)
      return ied_pkg::IED_EXC_INT_DIV;
    if (c == ied_pkg::IED_CLS_FP_ARITH && f != 5'h00) return ied_pkg::IED_EXC_FLOAT;
    return ied_pkg::IED_EXC_NONE;
  endfunction

  // Compares the three registered outputs against one expected type.
  task automatic check_out(input ied_pkg::ied_exc_t e);
    total_checks++;
    if (exc_type !== e || exc_vld !== (e != 0) || sup !== (e != 0)) begin
      error_cnt++;
      $display("[FAIL] exc report expected %0d seen type %0d valid %b suppress %b",
               e, exc_type, exc_vld, sup);
    end
  endtask

  // One instruction alone; its report is looked at in the one cycle it stands.
  task automatic send(input ied_pkg::ied_class_t c, input logic s,
                      input logic [31:0] a, input logic [31:0] b, input logic [4:0] f);
    model.present(c, s, a, b, f);
    model.go_idle();
    check_out(want(c, s, a, b, f));
  endtask

  task automatic t_trap();
    send(ied_pkg::IED_CLS_SW_TRAP, 1'b0, 32'h0, 32'h1, 5'h00);
  endtask

  // Every class placed in a delay slot, with operands that would fault anyway.
  task automatic t_slot();
    for (int k = 0; k < 10; k++)
      send(ied_pkg::ied_class_t'(k), 1'b1, 32'h8000_0000, 32'h0, 5'h1f);
  endtask

  task automatic t_general();
    send(ied_pkg::IED_CLS_UNDEFINED, 1'b0, 32'h0, 32'h0, 5'h00);
    send(ied_pkg::IED_CLS_OTHER, 1'b0, 32'h8000_0000, 32'h0, 5'h1f);
  endtask

  // Zero divisors, the one signed overflow, and its harmless neighbours.
  task automatic t_div();
    send(ied_pkg::IED_CLS_SIGNED_DIV, 1'b0, 32'h7, 32'h0, 5'h00);
    send(ied_pkg::IED_CLS_UNSIGN_DIV, 1'b0, 32'h7, 32'h0, 5'h00);
    send(ied_pkg::IED_CLS_SIGNED_DIV, 1'b0, 32'h8000_0000, 32'hffff_ffff, 5'h00);
    send(ied_pkg::IED_CLS_UNSIGN_DIV, 1'b0, 32'h8000_0000, 32'hffff_ffff, 5'h00);
    send(ied_pkg::IED_CLS_SIGNED_DIV, 1'b0, 32'h8000_0000, 32'h1, 5'h00);
    send(ied_pkg::IED_CLS_SIGNED_DIV, 1'b0, 32'h8000_0001, 32'hffff_ffff, 5'h00);
  endtask

  // Each float flag on its own, then no flag, then flags on a non-float class.
  task automatic t_fp();
    for (int k = 0; k < 5; k++)
      send(ied_pkg::IED_CLS_FP_ARITH, 1'b0, 32'h0, 32'h0, 5'h01 << k);
    send(ied_pkg::IED_CLS_FP_ARITH, 1'b0, 32'h0, 32'h0, 5'h00);
    send(ied_pkg::IED_CLS_WIDE, 1'b0, 32'h0, 32'h0, 5'h1f);
  endtask

  // Back-to-back faults: each report stands one cycle and carries one type.
  task automatic t_b2b();
    model.present(ied_pkg::IED_CLS_SW_TRAP, 1'b0, 32'h0, 32'h1, 5'h00);
    model.present(ied_pkg::IED_CLS_UNDEFINED, 1'b0, 32'h0, 32'h1, 5'h00);
    check_out(ied_pkg::IED_EXC_TRAP);
    model.present(ied_pkg::IED_CLS_UNSIGN_DIV, 1'b0, 32'h5, 32'h0, 5'h00);
    check_out(ied_pkg::IED_EXC_GEN_ILLEGAL);
    model.go_idle();
    check_out(ied_pkg::IED_EXC_INT_DIV);
    model.go_idle();
    check_out(ied_pkg::IED_EXC_NONE);
  endtask

  // Reset in mid-run swallows the trap it meets; the same trap held past the
  // release is the first instruction after reset and must be reported.
  task automatic t_reset();
    model.present(ied_pkg::IED_CLS_SW_TRAP, 1'b0, 32'h0, 32'h1, 5'h00);
    i_rst = 1'b1;
    @(posedge i_core_clk);
    #1;
    i_rst = 1'b0;
    check_out(ied_pkg::IED_EXC_NONE);
    model.go_idle();
    check_out(ied_pkg::IED_EXC_TRAP);
  endtask

  task automatic wrap_up();
    $display("Checks made %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang is cut short well past the fewer than a hundred cycles the run needs.
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    repeat (16) @(posedge i_core_clk);
    #1;
    i_rst = 1'b0;
    check_out(ied_pkg::IED_EXC_NONE);
    t_trap();
    t_slot();
    t_general();
    t_div();
    t_fp();
    t_b2b();
    t_reset();
    wrap_up();
  end
endmodule
